// ---- rtl/pcdi_pkg.sv ----
// package for the pulse counter and digital input block
// assumes a 100 MHz aclk and an axi4-lite slave holding the registers
package pcdi_pkg;
    localparam int CLK_HZ        = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    // timebase: 100 counts per period of a 50 kHz input
    localparam int FMAX_ACC_HZ   = 50_000;
    localparam int TB_COUNTS     = 100;
    localparam int TB_HZ         = FMAX_ACC_HZ * TB_COUNTS;
    localparam int TB_DIV        = CLK_HZ / TB_HZ;
    localparam int PER_MIN_NS    = 400;
    localparam int PER_MIN_CYC   = (PER_MIN_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int US_PER_S      = 1_000_000;
    localparam int US_DIV        = CLK_HZ / US_PER_S;
    localparam int NBITS         = 10;
    localparam int NCH           = 4;
    localparam int CW            = 24;

    localparam logic [7:0] OFS_DIR    = 8'h00;
    localparam logic [7:0] OFS_DOUT   = 8'h04;
    localparam logic [7:0] OFS_DIN    = 8'h08;
    localparam logic [7:0] OFS_RATE   = 8'h0c;
    localparam logic [7:0] OFS_CTRL   = 8'h10;
    localparam logic [7:0] OFS_STAT   = 8'h14;
    localparam logic [7:0] OFS_RES0   = 8'h20;
    localparam logic [7:0] OFS_AUX0   = 8'h30;

    localparam logic [9:0]  DIR_RESET  = 10'h3ff;
    localparam logic [31:0] RATE_RESET = 32'h000f4240;
    localparam logic [1:0]  RESP_OKAY  = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        PCDI_PERIOD, PCDI_FREQ, PCDI_RATE, PCDI_DUTY
    } pcdi_mode_t;
endpackage

// ---- rtl/pcdi_top.sv ----
// pulse counter channels and ten-bit digital port behind axi4-lite
// assumes bit pins are sampled from outside; each pin is three signals
//
// Contract
// - ten digital bits, each input or output
// - set direction bit means input, clear output
// - capture full ten-bit word each sample period; code reads output bits as zero
// - channel result latched once per sample period
// - period mode: 24-bit counter, report microseconds; code reports raw 0.2 us timebase counts
// - frequency mode reports hertz up to 1 MHz; code reports the period in 0.2 us timebase counts
// - frequency mode needs float output format
// - rate mode counts pulses per period, scaled; code reports the raw pulse count
// - duty: period and off-time 24-bit counters
// - duty result is high time over period; code reports the period, with off-time in aux
// - duty mode needs float output format
// - duty uses adjacent pair, odd line only
// - format float or unsigned, unsigned subset; code keeps the bit but always reports unsigned counts
// - non-rate modes accurate 0.5 Hz to 50 kHz
// - timebase gives 100 counts at 50 kHz
`timescale 1ns/1ns
`default_nettype none
module pcdi_top #(
    parameter int NBITS = 10,
    parameter int NCH   = 4
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [31:0]      s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [31:0]      s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic [NBITS-1:0] dio_in,
    output logic [NBITS-1:0]      dio_out,
    output logic [NBITS-1:0]      dio_oe,
    output logic                  sample_strobe
);
    localparam int CW = pcdi_pkg::CW;
    logic [NBITS-1:0] dir_reg;
    logic [NBITS-1:0] dout_reg;
    logic [31:0]      rate_reg;
    logic [2*NCH-1:0] mode_reg;
    logic [NCH-1:0]   fmt_float_reg;
    logic [NCH-1:0]   cfg_err_reg;
    logic [NBITS-1:0] din_reg;
    logic [31:0]      res_reg [NCH];
    logic [CW-1:0]    aux_reg [NCH];
    logic [NCH-1:0]   oor_reg;

    assign dio_out = dout_reg;
    assign dio_oe  = ~dir_reg;

    // three-flop chain; stages two and three feed edge logic
    logic [NBITS-1:0] sync1_reg;
    logic [NBITS-1:0] sync2_reg;
    logic [NBITS-1:0] sync3_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= dio_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end
    logic [NBITS-1:0] rise;
    logic [NBITS-1:0] fall;
    assign rise = sync2_reg & ~sync3_reg & dir_reg;
    assign fall = ~sync2_reg & sync3_reg & dir_reg;

    // sample period counter
    logic [31:0] sp_cnt_reg;
    logic        sp_tick;
    assign sp_tick = (sp_cnt_reg == 32'h0);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp_cnt_reg    <= pcdi_pkg::RATE_RESET - 32'h1;
            sample_strobe <= 1'b0;
        end else begin
            sample_strobe <= sp_tick;
            if (sp_tick || sp_cnt_reg >= rate_reg) begin
                sp_cnt_reg <= rate_reg - 32'h1;
            end else begin
                sp_cnt_reg <= sp_cnt_reg - 32'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            din_reg <= '0;
        end else if (sp_tick) begin
            din_reg <= sync2_reg & dir_reg;
        end
    end

    // timebase: one tick per 20 clocks, 100 ticks in 20 us
    logic [7:0] tb_cnt_reg;
    logic       tb_tick;
    assign tb_tick = (tb_cnt_reg == 8'(pcdi_pkg::TB_DIV - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tb_cnt_reg <= '0;
        end else begin
            tb_cnt_reg <= tb_tick ? 8'h0 : tb_cnt_reg + 8'h1;
        end
    end

    // channel k uses line 2k (odd numbered on the connector), pair 2k+1
    for (genvar k = 0; k < NCH; k++) begin : g_ch
        logic [CW-1:0] per_cnt_reg;
        logic [CW-1:0] off_cnt_reg;
        logic [CW-1:0] per_lat_reg;
        logic [CW-1:0] off_lat_reg;
        logic [CW-1:0] pulse_cnt_reg;
        logic          per_ovf_reg;
        logic [1:0]    md;
        logic          r;
        logic          f;
        assign md = mode_reg[2*k+1:2*k];
        assign r  = rise[2*k];
        assign f  = fall[2*k];

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                per_cnt_reg <= '0;
                off_cnt_reg <= '0;
                per_lat_reg <= '0;
                off_lat_reg <= '0;
                per_ovf_reg <= 1'b0;
            end else begin
                if (r) begin
                    per_lat_reg <= per_cnt_reg;
                    off_lat_reg <= off_cnt_reg;
                    per_cnt_reg <= '0;
                    off_cnt_reg <= '0;
                    per_ovf_reg <= 1'b0;
                end else begin
                    if (&per_cnt_reg) begin
                        per_ovf_reg <= 1'b1;
                        per_lat_reg <= per_cnt_reg;
                    end else if (tb_tick) begin
                        per_cnt_reg <= per_cnt_reg + CW'(1);
                    end
                    if (f) begin
                        off_cnt_reg <= '0;
                    end else if (tb_tick && !(&off_cnt_reg)) begin
                        off_cnt_reg <= off_cnt_reg + CW'(1);
                    end
                end
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pulse_cnt_reg <= '0;
            end else if (sp_tick) begin
                pulse_cnt_reg <= {{(CW-1){1'b0}}, r};
            end else if (r && !(&pulse_cnt_reg)) begin
                pulse_cnt_reg <= pulse_cnt_reg + CW'(1);
            end
        end

        // raw 0.2 us timebase counts (pulse count in rate mode), scaled by software; aux is off-time
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                res_reg[k] <= '0;
                aux_reg[k] <= '0;
                oor_reg[k] <= 1'b0;
            end else if (sp_tick) begin
                oor_reg[k] <= per_ovf_reg;
                aux_reg[k] <= off_lat_reg;
                unique case (md)
                    2'(pcdi_pkg::PCDI_RATE):
                        res_reg[k] <= {8'h0, pulse_cnt_reg};
                    default:
                        res_reg[k] <= {8'h0, per_lat_reg};
                endcase
            end
        end
    end

    // axi4-lite write: address and data taken in either order
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
    logic        wr_go;
    assign wr_go = aw_hold_reg && w_hold_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            aw_addr_reg  <= '0;
            w_data_reg   <= '0;
            w_strb_reg   <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= pcdi_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= pcdi_pkg::RESP_OKAY;
                unique case (aw_addr_reg)
                    pcdi_pkg::OFS_DIR, pcdi_pkg::OFS_DOUT,
                    pcdi_pkg::OFS_RATE, pcdi_pkg::OFS_CTRL: ;
                    default: s_axi_bresp <= pcdi_pkg::RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ctrl word: per channel nibble = {float, unused, mode[1:0]};
    // a float-only mode asked with unsigned format is refused
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_reg       <= pcdi_pkg::DIR_RESET;
            dout_reg      <= '0;
            rate_reg      <= pcdi_pkg::RATE_RESET;
            mode_reg      <= '0;
            fmt_float_reg <= '1;
            cfg_err_reg   <= '0;
        end else if (wr_go && (&w_strb_reg)) begin
            unique case (aw_addr_reg)
                pcdi_pkg::OFS_DIR:
                    dir_reg <= w_data_reg[NBITS-1:0];
                pcdi_pkg::OFS_DOUT:
                    dout_reg <= w_data_reg[NBITS-1:0];
                pcdi_pkg::OFS_RATE:
                    rate_reg <= w_data_reg;
                pcdi_pkg::OFS_CTRL:
                    for (int i = 0; i < NCH; i++) begin
                        if (!w_data_reg[4*i+3] &&
                            (w_data_reg[4*i+:2] ==
                                2'(pcdi_pkg::PCDI_FREQ) ||
                             w_data_reg[4*i+:2] ==
                                2'(pcdi_pkg::PCDI_DUTY))) begin
                            cfg_err_reg[i] <= 1'b1;
                        end else begin
                            cfg_err_reg[i] <= 1'b0;
                            mode_reg[2*i+:2] <= w_data_reg[4*i+:2];
                            fmt_float_reg[i] <= w_data_reg[4*i+3];
                        end
                    end
                default: ;
            endcase
        end
    end

    // axi4-lite read, one cycle after the address
    logic [7:0] ra;
    assign ra = s_axi_araddr[7:0];
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= pcdi_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= pcdi_pkg::RESP_OKAY;
            s_axi_rdata  <= '0;
            if (ra == pcdi_pkg::OFS_DIR)
                s_axi_rdata <= 32'(dir_reg);
            else if (ra == pcdi_pkg::OFS_DOUT)
                s_axi_rdata <= 32'(dout_reg);
            else if (ra == pcdi_pkg::OFS_DIN)
                s_axi_rdata <= 32'(din_reg);
            else if (ra == pcdi_pkg::OFS_RATE)
                s_axi_rdata <= rate_reg;
            else if (ra == pcdi_pkg::OFS_CTRL)
                for (int i = 0; i < NCH; i++)
                    s_axi_rdata[4*i+:4] <= {fmt_float_reg[i], 1'b0,
                                            mode_reg[2*i+:2]};
            else if (ra == pcdi_pkg::OFS_STAT)
                s_axi_rdata <= 32'({cfg_err_reg, oor_reg});
            else if (ra >= pcdi_pkg::OFS_RES0 && ra < 8'h30 &&
                     {1'b0, ra[3:2]} < 3'(NCH))
                s_axi_rdata <= res_reg[ra[3:2]];
            else if (ra >= pcdi_pkg::OFS_AUX0 && ra < 8'h40)
                s_axi_rdata <= 32'(aux_reg[ra[3:2]]);
            else
                s_axi_rresp <= pcdi_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    property p_dir_oe;
        @(posedge aclk) disable iff (!aresetn)
        wr_go && (&w_strb_reg) && aw_addr_reg == pcdi_pkg::OFS_DIR
            |=> dio_oe == ~$past(w_data_reg[NBITS-1:0]);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("oe wrong");
    property p_din;
        @(posedge aclk) disable iff (!aresetn)
        sp_tick |=> din_reg == ($past(sync2_reg) & $past(dir_reg));
    endproperty
    a_din: assert property (p_din) else $error("din bad");
    property p_strobe;
        @(posedge aclk) disable iff (!aresetn)
        sp_tick |=> sample_strobe;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe");
    logic [7:0] tb_gap_reg;
    always_ff @(posedge aclk) begin
        tb_gap_reg <= (!aresetn || tb_tick) ? 8'h0 : tb_gap_reg + 8'h1;
    end
    property p_tb;
        @(posedge aclk) disable iff (!aresetn)
        tb_tick == (tb_gap_reg == 8'(pcdi_pkg::TB_DIV - 1));
    endproperty
    a_tb: assert property (p_tb) else $error("timebase");
    property p_sync;
        @(posedge aclk) disable iff (!aresetn)
        rise[0] |-> $past(dio_in[0], 2) && !$past(dio_in[0], 3);
    endproperty
    a_sync: assert property (p_sync) else $error("edge");
    property p_mode_fmt;
        @(posedge aclk) disable iff (!aresetn)
        !fmt_float_reg[0] |-> mode_reg[1:0] != 2'(pcdi_pkg::PCDI_FREQ)
            && mode_reg[1:0] != 2'(pcdi_pkg::PCDI_DUTY);
    endproperty
    a_mode_fmt: assert property (p_mode_fmt) else $error("fmt");
    property p_sat;
        @(posedge aclk) disable iff (!aresetn)
        (&g_ch[0].per_cnt_reg) && !g_ch[0].r |=> g_ch[0].per_ovf_reg;
    endproperty
    a_sat: assert property (p_sat) else $error("ovf");
    property p_per_clr;
        @(posedge aclk) disable iff (!aresetn)
        g_ch[0].r |=> g_ch[0].per_cnt_reg == '0;
    endproperty
    a_per_clr: assert property (p_per_clr) else $error("per");
endmodule // pcdi_top
`default_nettype wire

// ---- sim/pcdi_pulse_src.sv ----
// external pulse sources for the four pulse counter channels
// assumes one aclk domain; all channels share one period and high time
`timescale 1ns/1ns
`default_nettype none
module pcdi_pulse_src #(
    parameter int NCH = 4
) (
    input  wire logic             aclk,
    input  wire logic [15:0]      per_cyc,
    input  wire logic [15:0]      hi_cyc,
    input  wire logic [NCH-1:0]   en,
    output logic [2*NCH-1:0]      lines
);
    logic [15:0] cnt = 16'h0000;
    logic        tog = 1'b0;

    // per_cyc never below 100 clocks, so the rate stays at 1 MHz or less
    always_ff @(posedge aclk) begin
        cnt <= (cnt >= per_cyc - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
        tog <= ~tog;
    end

    // signal only on the even pin of a pair; the other pin is left open,
    // so it shows a changing pattern rather than a stable level
    always_comb begin
        for (int k = 0; k < NCH; k++) begin
            lines[2*k]   = en[k] & (cnt < hi_cyc);
            lines[2*k+1] = tog;
        end
    end
endmodule // pcdi_pulse_src
`default_nettype wire

// ---- sim/pcdi_top_tb.sv ----
// self-checking bench for the pulse counter and digital port
// assumes the axi4-lite slave and ports of pcdi_top; pulses at 50 kHz
`timescale 1ns/1ns
`default_nettype none
module pcdi_top_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, v;
    logic [3:0]  wstrb = 4'h0, src_en = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, strobe;
    logic [1:0]  bresp, rresp, r;
    logic [1:0]  ext_hi = 2'b01;
    logic [7:0]  src;
    logic [9:0]  dio_in, dio_out, dio_oe;
    int          n_fail = 0, samples_checked = 0, c;

    // pins driven by the block win over the outside source
    assign dio_in = (dio_oe & dio_out) | (~dio_oe & {ext_hi, src});

    pcdi_top #(.NBITS(10), .NCH(4)) pcdi_top_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe),
        .sample_strobe(strobe)
    );

    pcdi_pulse_src #(.NCH(4)) pcdi_pulse_src_i (
        .aclk(aclk), .per_cyc(16'd2000), .hi_cyc(16'd600),
        .en(src_en), .lines(src)
    );

    initial forever #5 aclk = ~aclk;

    task automatic summarize;
        $display("checks %0d errors %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] lo,
                       input logic [31:0] hi, input string m);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t %s got %h", $time, m, got);
        end
    endtask

    // ready is sampled at the edge, before that edge's updates land
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= {24'h0, a};
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 200);
        r = bresp;
        chk({31'h0, bvalid}, 32'h1, 32'h1, "write answer");
        bready <= 1'b0;
        chk({30'h0, r}, 32'h0, 32'h0, "write response");
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 200);
        v = rdata;
        r = rresp;
        chk({31'h0, rvalid}, 32'h1, 32'h1, "read answer");
        rready <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] lo,
                      input logic [31:0] hi);
        rd(a);
        chk({30'h0, r}, 32'h0, 32'h0, "read response");
        chk(v, lo, hi, "read data");
    endtask

    task automatic ws;
        c = 0;
        do begin
            @(posedge aclk);
            c++;
        end while (strobe !== 1'b1 && c < 20000);
        chk({31'h0, strobe}, 32'h1, 32'h1, "sample strobe");
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rc(pcdi_pkg::OFS_DIR, 32'h3ff, 32'h3ff);
        chk({22'h0, dio_oe}, 32'h0, 32'h0, "oe after reset");
        rc(pcdi_pkg::OFS_RATE, 32'h000f4240, 32'h000f4240);
        rc(pcdi_pkg::OFS_CTRL, 32'h8888, 32'h8888);
        rc(pcdi_pkg::OFS_STAT, 32'h0, 32'h0);
        rd(8'h40);
        chk({30'h0, r}, 32'h2, 32'h2, "unmapped read");
        wr(pcdi_pkg::OFS_DIR, 32'h0ff, 4'hf);
        chk({22'h0, dio_oe}, 32'h300, 32'h300, "oe mask");
        wr(pcdi_pkg::OFS_DOUT, 32'h2a5, 4'hf);
        chk({22'h0, dio_out}, 32'h2a5, 32'h2a5, "dout");
        wr(pcdi_pkg::OFS_DOUT, 32'h0, 4'h3);
        chk({22'h0, dio_out}, 32'h2a5, 32'h2a5, "partial strobe");
        wr(pcdi_pkg::OFS_RATE, 32'd8000, 4'hf);
        wr(pcdi_pkg::OFS_CTRL, 32'hba98, 4'hf);
        src_en <= 4'hf;
        repeat (3) ws;
        rd(pcdi_pkg::OFS_DIN);
        chk({30'h0, v[9:8]}, 32'h0, 32'h0, "din outputs");
        wr(pcdi_pkg::OFS_DIR, 32'h3ff, 4'hf);
        repeat (2) ws;
        rd(pcdi_pkg::OFS_DIN);
        chk({30'h0, v[9:8]}, 32'h1, 32'h1, "din inputs");
        ws;
        ws;
        chk(c, 32'd8000, 32'd8000, "sample interval");
        // 50 kHz input: 100 timebase counts, 600 high of 2000 clocks
        rc(pcdi_pkg::OFS_RES0, 32'd99, 32'd101);
        rc(pcdi_pkg::OFS_RES0 + 8'h04, 32'd99, 32'd101);
        rc(pcdi_pkg::OFS_RES0 + 8'h08, 32'd3, 32'd5);
        rc(pcdi_pkg::OFS_RES0 + 8'h0c, 32'd99, 32'd101);
        rc(pcdi_pkg::OFS_AUX0 + 8'h0c, 32'd69, 32'd71);
        wr(pcdi_pkg::OFS_CTRL, 32'h3a13, 4'hf);
        rc(pcdi_pkg::OFS_CTRL, 32'hba98, 32'hba98);
        rd(pcdi_pkg::OFS_STAT);
        chk({28'h0, v[7:4]}, 32'hb, 32'hb, "config error");
        wr(pcdi_pkg::OFS_CTRL, 32'hba90, 4'hf);
        rc(pcdi_pkg::OFS_CTRL, 32'hba90, 32'hba90);
        summarize;
    end

    // about 60k cycles expected; cut off at 100k
    initial begin
        #1_000_000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize;
    end
endmodule // pcdi_top_tb
`default_nettype wire
